// ==== shared/record_pkg.sv ====
package record_pkg;
  // =========================================================
  // register map (byte addresses on the wishbone bus)
  localparam logic [7:0] ADR_CTRL   = 8'h00;
  localparam logic [7:0] ADR_INDEX  = 8'h04;
  localparam logic [7:0] ADR_WDATA  = 8'h08;
  localparam logic [7:0] ADR_RDATA  = 8'h0C;
  localparam logic [7:0] ADR_STATUS = 8'h10;
  localparam int CTRL_COMMIT_BIT = 16;
  localparam int ST_ERR_BIT      = 8;
  localparam int ST_TS_BIT       = 9;
  localparam int ST_SUP_BIT      = 10;
  // =========================================================
  // record numbers
  localparam logic [7:0] REC_CFG      = 8'h02;
  localparam logic [7:0] REC_DIRECT   = 8'h32;
  localparam logic [7:0] REC_SUPPRESS = 8'h33;
  localparam logic [7:0] REC_FIELD1   = 8'h64;
  localparam logic [7:0] REC_F2_FIRST = 8'h65;
  localparam logic [7:0] REC_F2_LAST  = 8'h84;
  localparam logic [7:0] REC_PROD     = 8'h96;
  localparam logic [7:0] REC_STBY     = 8'h97;
  localparam logic [7:0] REC_DIAG     = 8'h98;
  localparam logic [7:0] REC_FAN      = 8'hA0;
  localparam logic [7:0] REC_MEAS     = 8'hC8;
  localparam logic [7:0] REC_VER      = 8'hC9;
  // =========================================================
  // record lengths in bytes
  localparam logic [7:0] LEN_CFG       = 8'h19;
  localparam logic [7:0] LEN_DIRECT    = 8'h1A;
  localparam logic [7:0] LEN_SUPPRESS  = 8'h17;
  localparam logic [7:0] LEN_FIELD1    = 8'h80;
  localparam logic [7:0] LEN_FIELD2    = 8'h30;
  localparam logic [7:0] LEN_SETP      = 8'h20;
  localparam logic [7:0] LEN_DIAG      = 8'h1B;
  localparam logic [7:0] LEN_FAN       = 8'h01;
  localparam logic [7:0] LEN_MEAS_ENT  = 8'h0A;
  localparam logic [7:0] LEN_VER_HDR   = 8'h0E;
  localparam logic [7:0] LEN_VER_ENT   = 8'h06;
  localparam logic [7:0] CFG_FLAG_BYTE = 8'h18;
  localparam int MAX_MODULES = 24;
  localparam int CFG_WORDS   = 12;
  localparam int CH_PER_MOD  = 6;
  localparam int STAGE_BYTES = 26;
  // =========================================================
  // key texts, first character in the top byte
  localparam logic [8*26-1:0] KEY_DIRECT   = "!SETPOINT WITHOUT TRIGGER!";
  localparam logic [8*23-1:0] KEY_SUPPRESS = "!WITHOUT VOLTAGE ERROR!";
  // =========================================================
  typedef struct packed {
    logic        cyc;
    logic        stb;
    logic        we;
    logic [7:0]  adr;
    logic [3:0]  sel;
    logic [31:0] dat;
  } wbReq_t;
  typedef struct packed {
    logic        ack;
    logic [31:0] dat;
  } wbRsp_t;
  typedef struct packed {
    logic                                  ack;
    logic [31:0]                           rdat;
    logic [7:0]                            rec;
    logic [4:0]                            modSel;
    logic [7:0]                            idx;
    logic [STAGE_BYTES-1:0][7:0]           stage;
    logic [4:0]                            stageLen;
    logic                                  stageOvf;
    logic                                  errFlag;
    logic                                  tsOff;
    logic                                  supOn;
    logic [3:0]                            errOut;
    logic [STAGE_BYTES-1:0][7:0]           dsText;
    logic [MAX_MODULES-1:0][CFG_WORDS-1:0][15:0] cfgWord;
    logic [MAX_MODULES-1:0][CH_PER_MOD-1:0]      parFlag;
  } handlerState_t;
endpackage

// ==== design/reset_sync.sv ====
`timescale 1ns/10ps
module reset_sync (
  input  wire logic clk,       // system clock
  input  wire logic rst_n,     // raw asynchronous reset
  output logic      rstSync_n  // released two edges late
);
  logic stage1_reg;
  // =========================================================
  // two-flop release; assertion stays asynchronous
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      stage1_reg <= 1'b0;
      rstSync_n  <= 1'b0;
    end else begin
      stage1_reg <= 1'b1;
      rstSync_n  <= stage1_reg;
    end
  end
endmodule

// ==== design/key_checker.sv ====
`timescale 1ns/10ps
module key_checker #(
  parameter int              N   = 1,
  parameter logic [8*N-1:0]  KEY = '0
) (
  input  wire logic [25:0][7:0] text,   // staged bytes, byte 0 first
  input  wire logic [4:0]       len,    // bytes staged
  input  wire logic             ovf,    // too many bytes staged
  output logic                  match   // exact key and length
);
  logic [N-1:0] hit;
  // =========================================================
  // one comparator per key character
  genvar i;
  generate
    for (i = 0; i < N; i++) begin : g_chr
      assign hit[i] = (text[i] == KEY[8*(N-1-i) +: 8]);
    end
  endgenerate
  // any wrong character or length refuses the key
  assign match = (&hit) && (len == 5'(N)) && !ovf;
endmodule

// ==== design/acyclic_record_handler.sv ====
// Design decisions made here: the register addresses and the Wishbone register port.
`timescale 1ns/10ps
// What this block does
// - config record holds six power and deviation word pairs, bytes 0-23
// - one parallel-load flag per channel follows, default zero
// - config write replaces config; error if module not high-end
// - exact direct-switch key permanently disables setpoint time scale
// - any wrong key character rejects the command with error
// - exact suppress key permanently masks four supply errors heating off
// - range-field read always full 32 fields, unassigned read zero
// - direct-field read always 24 entries, unassigned read zero
// - setpoint reads always 32 bytes, unused fields read zero
// - diagnostic mask read shows only existing channel bits
// - fan record read returns fan setting in effect
// - config read returns current parameters of addressed module
// - direct-switch read while active returns the written text
// - measured values give ten-byte entry per module, up to 24
// - measured record length follows number of modules in use
// - version record has 14-byte header then per-module entries
// - firmware versions are char plus three bytes, hardware one byte
// - version length follows modules; header always present
module acyclic_record_handler
  import record_pkg::*;
(
  input  wire logic                   clk,          // 100 MHz clock
  input  wire logic                   rst_n,        // async reset, low
  input  wire wbReq_t                 wbReq,        // wishbone request
  output wbRsp_t                      wbRsp,        // wishbone answer
  input  wire logic [4:0]             pomCount,     // modules in use
  input  wire logic [MAX_MODULES-1:0] highEndMask,  // high-end modules
  input  wire logic [7:0]             lookupByte,   // system record byte
  input  wire logic [7:0]             lookupMask,   // valid bits of it
  output logic [7:0]                  lookupRecord, // record looked up
  output logic [4:0]                  lookupModule, // module looked up
  output logic [7:0]                  lookupIndex,  // byte looked up
  input  wire logic                   heatingOn,    // heating enabled
  input  wire logic [3:0]             supplyErrIn,  // raw supply errors
  output logic [3:0]                  supplyErrOut, // errors reported
  output logic                        timeScaleOff  // time scale bypass
);
  handlerState_t s_reg;
  handlerState_t s_next;
  logic          rstSync_n;
  logic          dsKeyOk;
  logic          supKeyOk;
  logic          busReq;
  logic          cmdCommit;
  logic          modHighEnd;
  logic [7:0]    recLen;
  logic [7:0]    rdByte;
  logic [15:0]   cfgSel;

  // =========================================================
  // reset release and key comparators
  reset_sync u_rst (
    .clk       (clk),
    .rst_n     (rst_n),
    .rstSync_n (rstSync_n)
  );

  key_checker #(.N(26), .KEY(KEY_DIRECT)) u_keyDirect (
    .text  (s_reg.stage),
    .len   (s_reg.stageLen),
    .ovf   (s_reg.stageOvf),
    .match (dsKeyOk)
  );

  key_checker #(.N(23), .KEY(KEY_SUPPRESS)) u_keySuppress (
    .text  (s_reg.stage),
    .len   (s_reg.stageLen),
    .ovf   (s_reg.stageOvf),
    .match (supKeyOk)
  );

  // =========================================================
  // bus decode helpers
  assign busReq    = wbReq.cyc && wbReq.stb && !s_reg.ack;
  assign cmdCommit = busReq && wbReq.we && (wbReq.adr == ADR_CTRL)
                     && wbReq.sel[2] && wbReq.dat[CTRL_COMMIT_BIT];
  // out-of-range module numbers count as not high-end
  assign modHighEnd = (s_reg.modSel < 5'(MAX_MODULES))
                      && highEndMask[s_reg.modSel];

  // =========================================================
  // record length as the addressed record would report it
  always_comb begin
    recLen = 8'h00;
    if (s_reg.rec == REC_CFG) begin
      recLen = modHighEnd ? LEN_CFG : 8'h00;
    end else if (s_reg.rec == REC_DIRECT) begin
      recLen = s_reg.tsOff ? LEN_DIRECT : 8'h00;
    end else if (s_reg.rec == REC_SUPPRESS) begin
      recLen = s_reg.supOn ? LEN_SUPPRESS : 8'h00;
    end else if (s_reg.rec == REC_FIELD1) begin
      recLen = LEN_FIELD1;
    end else if (s_reg.rec >= REC_F2_FIRST && s_reg.rec <= REC_F2_LAST) begin
      recLen = LEN_FIELD2;
    end else if (s_reg.rec == REC_PROD || s_reg.rec == REC_STBY) begin
      recLen = LEN_SETP;
    end else if (s_reg.rec == REC_DIAG) begin
      recLen = LEN_DIAG;
    end else if (s_reg.rec == REC_FAN) begin
      recLen = LEN_FAN;
    end else if (s_reg.rec == REC_MEAS) begin
      recLen = 8'(LEN_MEAS_ENT * pomCount);
    end else if (s_reg.rec == REC_VER) begin
      // header stays even with no supply monitor module fitted
      recLen = 8'(LEN_VER_HDR + LEN_VER_ENT * pomCount);
    end
  end

  // =========================================================
  // one byte of the addressed record at the current index
  assign cfgSel = s_reg.cfgWord[s_reg.modSel][s_reg.idx[4:1]];

  always_comb begin
    rdByte = 8'h00;
    if (s_reg.idx < recLen) begin
      if (s_reg.rec == REC_CFG) begin
        if (s_reg.idx == CFG_FLAG_BYTE) begin
          rdByte = {2'b00, s_reg.parFlag[s_reg.modSel]};
        end else begin
          // high byte at the even offset
          rdByte = s_reg.idx[0] ? cfgSel[7:0] : cfgSel[15:8];
        end
      end else if (s_reg.rec == REC_DIRECT) begin
        rdByte = s_reg.dsText[s_reg.idx[4:0]];
      end else if (s_reg.rec == REC_SUPPRESS) begin
        rdByte = KEY_SUPPRESS[8*(22-s_reg.idx[4:0]) +: 8];
      end else begin
        // mask zeroes unassigned fields and absent channels
        rdByte = lookupByte & lookupMask;
      end
    end
  end

  // system tables are addressed straight from the control fields
  assign lookupRecord = s_reg.rec;
  assign lookupModule = s_reg.modSel;
  assign lookupIndex  = s_reg.idx;
  assign wbRsp.ack    = s_reg.ack;
  assign wbRsp.dat    = s_reg.rdat;
  assign supplyErrOut = s_reg.errOut;
  assign timeScaleOff = s_reg.tsOff;

  // =========================================================
  // next state: bus slave, staging and record commands
  always_comb begin
    s_next     = s_reg;
    s_next.ack = busReq;
    // four supply errors dropped while suppression is on and heating is off
    s_next.errOut = (s_reg.supOn && !heatingOn) ? 4'h0 : supplyErrIn;
    if (busReq && wbReq.we) begin
      if (wbReq.adr == ADR_CTRL) begin
        if (wbReq.sel[0]) begin
          s_next.rec = wbReq.dat[7:0];
        end
        if (wbReq.sel[1]) begin
          s_next.modSel = wbReq.dat[12:8];
        end
      end else if (wbReq.adr == ADR_INDEX) begin
        if (wbReq.sel[0]) begin
          s_next.idx = wbReq.dat[7:0];
        end
      end else if (wbReq.adr == ADR_WDATA) begin
        // bytes past the buffer end are dropped and spoil the commit
        if (wbReq.sel[0]) begin
          if (s_reg.stageLen < 5'(STAGE_BYTES)) begin
            s_next.stage[s_reg.stageLen] = wbReq.dat[7:0];
            s_next.stageLen = s_reg.stageLen + 5'h01;
          end else begin
            s_next.stageOvf = 1'b1;
          end
        end
      end else if (wbReq.adr == ADR_STATUS) begin
        if (wbReq.sel[1] && wbReq.dat[ST_ERR_BIT]) begin
          s_next.errFlag = 1'b0;
        end
      end
    end
    if (busReq && !wbReq.we) begin
      s_next.rdat = 32'h0000_0000;
      if (wbReq.adr == ADR_CTRL) begin
        s_next.rdat = {19'h0, s_reg.modSel, s_reg.rec};
      end else if (wbReq.adr == ADR_INDEX) begin
        s_next.rdat = {24'h0, s_reg.idx};
      end else if (wbReq.adr == ADR_RDATA) begin
        // reading steps the index so a record streams out
        s_next.rdat = {24'h0, rdByte};
        s_next.idx  = s_reg.idx + 8'h01;
      end else if (wbReq.adr == ADR_STATUS) begin
        s_next.rdat = {21'h0, s_reg.supOn, s_reg.tsOff,
                       s_reg.errFlag, recLen};
      end
    end
    if (cmdCommit) begin
      s_next.stageLen = 5'h00;
      s_next.stageOvf = 1'b0;
      s_next.errFlag  = 1'b0;
      if (s_reg.rec == REC_CFG) begin
        if (!modHighEnd || s_reg.stageOvf
            || s_reg.stageLen != LEN_CFG[4:0]) begin
          s_next.errFlag = 1'b1;
        end else begin
          for (int w = 0; w < CFG_WORDS; w++) begin
            s_next.cfgWord[s_reg.modSel][w] =
              {s_reg.stage[2*w], s_reg.stage[2*w+1]};
          end
          s_next.parFlag[s_reg.modSel] =
            s_reg.stage[CFG_FLAG_BYTE][5:0];
        end
      end else if (s_reg.rec == REC_DIRECT) begin
        if (dsKeyOk) begin
          s_next.tsOff  = 1'b1;
          s_next.dsText = s_reg.stage;
        end else begin
          s_next.errFlag = 1'b1;
        end
      end else if (s_reg.rec == REC_SUPPRESS) begin
        if (supKeyOk) begin
          s_next.supOn = 1'b1;
        end else begin
          s_next.errFlag = 1'b1;
        end
      end else begin
        // other records are written elsewhere
        s_next.errFlag = 1'b1;
      end
    end
  end

  // =========================================================
  // state register; parallel flags default to no
  always_ff @(posedge clk or negedge rstSync_n) begin
    if (!rstSync_n) begin
      s_reg <= '0;
    end else begin
      s_reg <= s_next;
    end
  end

  // =========================================================
  // checks
  sequence s_commitTo(logic [7:0] r);
    cmdCommit && (s_reg.rec == r);
  endsequence

  sequence s_cfgGood;
    s_commitTo(REC_CFG) ##0 (modHighEnd && !s_reg.stageOvf
                             && s_reg.stageLen == LEN_CFG[4:0]);
  endsequence

  property p_cfgWrite;
    @(posedge clk) disable iff (!rstSync_n)
    s_cfgGood |=> s_reg.cfgWord[$past(s_reg.modSel)][0] ==
                  {$past(s_reg.stage[0]), $past(s_reg.stage[1])};
  endproperty
  a_cfgWrite: assert property (p_cfgWrite)
    else $error("config word not taken high byte first");

  property p_parFlag;
    @(posedge clk) disable iff (!rstSync_n)
    s_cfgGood |=> s_reg.parFlag[$past(s_reg.modSel)] ==
                  $past(s_reg.stage[CFG_FLAG_BYTE][5:0]);
  endproperty
  a_parFlag: assert property (p_parFlag)
    else $error("parallel flags not taken");

  property p_cfgReject;
    @(posedge clk) disable iff (!rstSync_n)
    s_commitTo(REC_CFG) ##0 !modHighEnd |=>
      s_reg.errFlag && $stable(s_reg.cfgWord) && $stable(s_reg.parFlag);
  endproperty
  a_cfgReject: assert property (p_cfgReject)
    else $error("config write to non high-end module not refused");

  property p_tsSticky;
    @(posedge clk) disable iff (!rstSync_n)
    $rose(s_reg.tsOff) |-> timeScaleOff ##1 timeScaleOff [*4];
  endproperty
  a_tsSticky: assert property (p_tsSticky)
    else $error("time scale bypass was undone");

  property p_keyReject;
    @(posedge clk) disable iff (!rstSync_n)
    s_commitTo(REC_DIRECT) ##0 (!dsKeyOk && !s_reg.tsOff) |=>
      !timeScaleOff && s_reg.errFlag;
  endproperty
  a_keyReject: assert property (p_keyReject)
    else $error("wrong key executed or not flagged");

  property p_supGate;
    @(posedge clk) disable iff (!rstSync_n)
    (s_reg.supOn && !heatingOn) |=> (supplyErrOut == 4'h0);
  endproperty
  a_supGate: assert property (p_supGate)
    else $error("supply error passed while suppressed");

  property p_fieldZero;
    @(posedge clk) disable iff (!rstSync_n)
    (s_reg.rec == REC_FIELD1 && lookupMask == 8'h00) |->
      (rdByte == 8'h00 && recLen == LEN_FIELD1);
  endproperty
  a_fieldZero: assert property (p_fieldZero)
    else $error("unassigned field not zero or short record");

  property p_verLen;
    @(posedge clk) disable iff (!rstSync_n)
    (s_reg.rec == REC_VER && pomCount == 5'h00) |-> recLen == LEN_VER_HDR;
  endproperty
  a_verLen: assert property (p_verLen)
    else $error("version header missing");

  property p_cfgMsb;
    @(posedge clk) disable iff (!rstSync_n)
    (s_reg.rec == REC_CFG && modHighEnd && s_reg.idx == 8'h00) |->
      rdByte == s_reg.cfgWord[s_reg.modSel][0][15:8];
  endproperty
  a_cfgMsb: assert property (p_cfgMsb)
    else $error("config word not read high byte first");

  property p_supSticky;
    @(posedge clk) disable iff (!rstSync_n)
    $rose(s_reg.supOn) |-> s_reg.supOn ##1 s_reg.supOn [*4];
  endproperty
  a_supSticky: assert property (p_supSticky)
    else $error("supply error suppression was undone");

  property p_supKeyReject;
    @(posedge clk) disable iff (!rstSync_n)
    s_commitTo(REC_SUPPRESS) ##0 (!supKeyOk && !s_reg.supOn) |=>
      !s_reg.supOn && s_reg.errFlag;
  endproperty
  a_supKeyReject: assert property (p_supKeyReject)
    else $error("wrong suppress key executed or not flagged");

  property p_dsEcho;
    @(posedge clk) disable iff (!rstSync_n)
    s_commitTo(REC_DIRECT) ##0 dsKeyOk |=>
      s_reg.dsText == $past(s_reg.stage);
  endproperty
  a_dsEcho: assert property (p_dsEcho)
    else $error("accepted switch text not kept for read back");

  property p_setpLen;
    @(posedge clk) disable iff (!rstSync_n)
    (s_reg.rec == REC_PROD || s_reg.rec == REC_STBY) |-> recLen == LEN_SETP;
  endproperty
  a_setpLen: assert property (p_setpLen)
    else $error("setpoint record not full length");

  property p_measLen;
    @(posedge clk) disable iff (!rstSync_n)
    (s_reg.rec == REC_MEAS && pomCount == 5'h00) |-> recLen == 8'h00;
  endproperty
  a_measLen: assert property (p_measLen)
    else $error("measured record not empty with no modules");
endmodule

// ==== tb/record_source.sv ====
`timescale 1ns/10ps
// =========================================================
// system record source standing in for the module data path
module record_source
  import record_pkg::*;
(
  input  wire logic [7:0] lookupRecord, // record looked up
  input  wire logic [4:0] lookupModule, // module looked up
  input  wire logic [7:0] lookupIndex,  // byte looked up
  output logic      [7:0] lookupByte,   // byte of that record
  output logic      [7:0] lookupMask    // valid bits of it
);
  // pattern changes with every byte and module, so a stuck index shows up
  assign lookupByte = lookupIndex ^ lookupRecord
                      ^ {3'h0, lookupModule};
  // top bit kept invalid to prove the mask is applied; upper range
  // fields stand unassigned and must read back as zero
  assign lookupMask = (lookupRecord == REC_FIELD1 && lookupIndex[6])
                      ? 8'h00 : 8'h7F;
endmodule

// ==== tb/acyclic_record_handler_test.sv ====
`timescale 1ns/10ps
module acyclic_record_handler_test;
  import record_pkg::*;
  logic clk, rst_n, heatingOn;
  wbReq_t wbReq;
  wbRsp_t wbRsp;
  logic [4:0] pomCount, lookupModule;
  logic [23:0] highEndMask;
  logic [7:0] lookupByte, lookupMask, lookupRecord, lookupIndex;
  logic [3:0] supplyErrIn, supplyErrOut;
  logic timeScaleOff;
  int miscompares = 0;
  int checksDone = 0;
  acyclic_record_handler i_acyclic_record_handler (
    .clk(clk), .rst_n(rst_n), .wbReq(wbReq), .wbRsp(wbRsp),
    .pomCount(pomCount), .highEndMask(highEndMask),
    .lookupByte(lookupByte), .lookupMask(lookupMask),
    .lookupRecord(lookupRecord), .lookupModule(lookupModule),
    .lookupIndex(lookupIndex), .heatingOn(heatingOn),
    .supplyErrIn(supplyErrIn), .supplyErrOut(supplyErrOut),
    .timeScaleOff(timeScaleOff));
  record_source i_record_source (
    .lookupRecord(lookupRecord), .lookupModule(lookupModule),
    .lookupIndex(lookupIndex), .lookupByte(lookupByte),
    .lookupMask(lookupMask));
  // =========================================================
  // common tasks
  task automatic complete_run;
    $display("checksDone=%0d miscompares=%0d", checksDone, miscompares);
    if (miscompares == 0 && checksDone > 0) begin
      $display("Simulation passed");
    end else begin
      $display("Simulation failed");
    end
    $finish;
  endtask
  task automatic check(input logic [31:0] seen, input logic [31:0] exp);
    checksDone++;
    if (seen !== exp) begin
      miscompares++;
      $display("BAD t=%0t seen=%h exp=%h", $time, seen, exp);
    end
  endtask
  // one classic cycle; request held until ack is sampled high
  task automatic wb(input logic w, input logic [7:0] a, input logic [3:0] s,
                    input logic [31:0] d, output logic [31:0] q);
    int n;
    @(posedge clk);
    wbReq <= '{cyc: 1'b1, stb: 1'b1, we: w, adr: a, sel: s, dat: d};
    n = 0;
    do begin
      @(posedge clk);
      n++;
    end while (wbRsp.ack !== 1'b1 && n < 20);
    q = wbRsp.dat;
    wbReq <= '0;
    if (wbRsp.ack !== 1'b1) begin
      miscompares++;
      complete_run();
    end
  endtask
  task automatic wr(input logic [7:0] a, input logic [3:0] s,
                    input logic [31:0] d);
    logic [31:0] q;
    wb(1'b1, a, s, d, q);
  endtask
  task automatic rd(input logic [7:0] a, output logic [31:0] q);
    wb(1'b0, a, 4'hF, 32'h0, q);
  endtask
  task automatic point(input logic [7:0] rec, input logic [4:0] m);
    wr(ADR_CTRL, 4'h3, {19'h0, m, rec});
    wr(ADR_INDEX, 4'h1, 32'h0);
  endtask
  task automatic commit(input logic [7:0] rec, input logic [4:0] m);
    // select first: a commit acts on the record and module already held
    wr(ADR_CTRL, 4'h3, {19'h0, m, rec});
    wr(ADR_CTRL, 4'h7, {15'h0, 1'b1, 3'h0, m, rec});
  endtask
  // key bytes go out first character first; bad picks a byte to spoil
  task automatic stage_key(input logic [8*26-1:0] k, input int n,
                           input int bad);
    logic [7:0] b;
    for (int i = 0; i < n; i++) begin
      b = k[8*(n-1-i)+:8];
      if (i == bad) b = b ^ 8'h01;
      wr(ADR_WDATA, 4'h1, {24'h0, b});
    end
  endtask
  // =========================================================
  // scenarios
  task automatic test_config;
    logic [31:0] q;
    rd(ADR_STATUS, q);
    check(q, 32'h0);
    point(REC_CFG, 5'h01);
    wr(ADR_INDEX, 4'h1, 32'h18);
    rd(ADR_RDATA, q);
    check(q[7:0], 8'h00);
    for (int i = 0; i < 24; i++) wr(ADR_WDATA, 4'h1, 32'h10 + i);
    wr(ADR_WDATA, 4'h1, 32'h2A);
    commit(REC_CFG, 5'h01);
    rd(ADR_STATUS, q);
    check(q[8], 1'b0);
    check(q[7:0], LEN_CFG);
    point(REC_CFG, 5'h01);
    for (int i = 0; i < 24; i++) begin
      rd(ADR_RDATA, q);
      check(q[7:0], 8'h10 + i);
    end
    rd(ADR_RDATA, q);
    check(q[7:0], 8'h2A);
    rd(ADR_RDATA, q);
    check(q, 32'h0);
    // module 0 is not high-end, so a full-length write must be refused
    for (int i = 0; i < 25; i++) wr(ADR_WDATA, 4'h1, 32'h55);
    commit(REC_CFG, 5'h00);
    rd(ADR_STATUS, q);
    check(q[8], 1'b1);
    check(q[7:0], 8'h00);
  endtask
  task automatic test_direct;
    logic [31:0] q;
    stage_key(KEY_DIRECT, 26, 5);
    commit(REC_DIRECT, 5'h00);
    rd(ADR_STATUS, q);
    check(q[9:8], 2'b01);
    check(timeScaleOff, 1'b0);
    stage_key(KEY_DIRECT, 26, 99);
    commit(REC_DIRECT, 5'h00);
    rd(ADR_STATUS, q);
    check(q[9:8], 2'b10);
    check(timeScaleOff, 1'b1);
    point(REC_DIRECT, 5'h00);
    rd(ADR_STATUS, q);
    check(q[7:0], LEN_DIRECT);
    rd(ADR_RDATA, q);
    check(q[7:0], KEY_DIRECT[207:200]);
  endtask
  task automatic test_suppress;
    logic [31:0] q;
    @(posedge clk);
    heatingOn <= 1'b0;
    supplyErrIn <= 4'hF;
    repeat (3) @(posedge clk);
    check(supplyErrOut, 4'hF);
    stage_key(KEY_SUPPRESS, 23, 22);
    commit(REC_SUPPRESS, 5'h00);
    rd(ADR_STATUS, q);
    check(q[10:8], 3'b011);
    check(supplyErrOut, 4'hF);
    stage_key(KEY_SUPPRESS, 23, 99);
    commit(REC_SUPPRESS, 5'h00);
    rd(ADR_STATUS, q);
    check(q[10:8], 3'b110);
    check(supplyErrOut, 4'h0);
    @(posedge clk);
    heatingOn <= 1'b1;
    repeat (3) @(posedge clk);
    check(supplyErrOut, 4'hF);
    check(timeScaleOff, 1'b1);
  endtask
  task automatic test_lengths;
    logic [31:0] q;
    logic [7:0] recs [9];
    logic [7:0] lens [9];
    recs = '{REC_FIELD1, REC_F2_FIRST, REC_F2_LAST, REC_PROD, REC_STBY,
             REC_DIAG, REC_FAN, REC_MEAS, REC_VER};
    // three modules in use: 3 x 10 and 14 + 3 x 6
    lens = '{LEN_FIELD1, LEN_FIELD2, LEN_FIELD2, LEN_SETP, LEN_SETP,
             LEN_DIAG, LEN_FAN, 8'h1E, 8'h20};
    for (int i = 0; i < 9; i++) begin
      point(recs[i], 5'h00);
      rd(ADR_STATUS, q);
      check(q[7:0], lens[i]);
      rd(ADR_RDATA, q);
      check(q[7:0], recs[i] & 8'h7F);
    end
    wr(ADR_INDEX, 4'h1, 32'h01);
    rd(ADR_RDATA, q);
    check(q[7:0], 8'h01 ^ REC_VER & 8'h7F);
    point(REC_FAN, 5'h00);
    wr(ADR_INDEX, 4'h1, 32'h01);
    rd(ADR_RDATA, q);
    check(q, 32'h0);
    point(REC_FIELD1, 5'h03);
    rd(ADR_RDATA, q);
    check(q[7:0], (REC_FIELD1 ^ 8'h03) & 8'h7F);
    wr(ADR_INDEX, 4'h1, 32'h7F);
    rd(ADR_RDATA, q);
    check(q, 32'h0);
    @(posedge clk);
    pomCount <= 5'h00;
    point(REC_MEAS, 5'h00);
    rd(ADR_STATUS, q);
    check(q[7:0], 8'h00);
    point(REC_VER, 5'h00);
    rd(ADR_STATUS, q);
    check(q[7:0], LEN_VER_HDR);
    rd(8'h40, q);
    check(q, 32'h0);
  endtask
  // =========================================================
  // clock, reset and main sequence
  initial begin
    clk = 1'b0;
    forever #5 clk = ~clk;
  end
  initial begin
    wbReq = '0;
    rst_n = 1'b0;
    heatingOn = 1'b1;
    supplyErrIn = 4'h0;
    pomCount = 5'h03;
    highEndMask = 24'h000002;
    repeat (4) @(posedge clk);
    rst_n <= 1'b1;
    // two sync flops delay the release inside the block
    repeat (3) @(posedge clk);
    test_config();
    test_direct();
    test_suppress();
    test_lengths();
    complete_run();
  end
endmodule
